// ==== plc_interrupt_event_prioritizer.v ====
// Purpose: latch interrupt events, pick the highest-ranked one, hand it to the core
// Assumes: event pulses come from clk-domain logic; discrete inputs are raw pins
// Notes: event_valid_q holds until event_take; the taken event's flag clears then
`timescale 1ns/1ns
`include "event_prio_regs.vh"
module plc_interrupt_event_prioritizer (
  input wire clk,
  input wire rst_b,
  input wire port0_rx_char,
  input wire port0_tx_done,
  input wire port0_rx_msg,
  input wire port1_rx_msg,
  input wire port1_rx_char,
  input wire port1_tx_done,
  input wire pulse_train_out_0_done,
  input wire pulse_train_out_1_done,
  input wire [3:0] discrete_input,
  input wire [5:0] count_match,
  input wire [4:0] count_dir_change,
  input wire [4:0] count_ext_reset,
  input wire [1:0] timed_tick,
  input wire fast_on_delay_timer_a_done,
  input wire fast_on_delay_timer_b_done,
  input wire event_take,
  output reg event_valid_q,
  output reg [5:0] event_num_q,
  output reg [1:0] event_group_q,
  output reg [4:0] event_rank_q
);
  // flat priority list: index 0 is the highest overall rank
  localparam N = `EV_COUNT;
  // dir/reset inputs: bits 0,1,2,4 used (counters 0,1,2,4); bit 3 unused for counter 3
  wire [3:0] din_lvl;
  reg [3:0] din_prev_q;
  reg din_armed_q;
  wire [3:0] rise;
  wire [3:0] fall;
  wire [N-1:0] raw_ev;
  wire [N-1:0] pend;
  reg [N-1:0] take_vec;
  reg [5:0] sel_idx;
  reg sel_any;
  reg [5:0] num_of;
  reg [1:0] grp_of;
  reg [4:0] rank_of;
  integer i;
  integer j;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_din
      input_sync u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .pin(discrete_input[g]),
        .level_q(din_lvl[g])
      );
    end
  endgenerate

  always @(posedge clk) begin
    if (!rst_b) begin
      din_prev_q <= 4'h0;
      din_armed_q <= 1'b0;
    end else begin
      din_prev_q <= din_lvl;
      // skip the first compare so reset level is not seen as an edge
      din_armed_q <= 1'b1;
    end
  end

  assign rise = din_armed_q ? (din_lvl & ~din_prev_q) : 4'h0;
  assign fall = din_armed_q ? (~din_lvl & din_prev_q) : 4'h0;

  // order of raw_ev is the ranking order
  assign raw_ev[0] = port0_rx_char;
  assign raw_ev[1] = port0_tx_done;
  assign raw_ev[2] = port0_rx_msg;
  assign raw_ev[3] = port1_rx_msg;
  assign raw_ev[4] = port1_rx_char;
  assign raw_ev[5] = port1_tx_done;
  assign raw_ev[6] = pulse_train_out_0_done;
  assign raw_ev[7] = pulse_train_out_1_done;
  assign raw_ev[11:8] = rise;
  assign raw_ev[15:12] = fall;
  assign raw_ev[16] = count_match[0];
  assign raw_ev[17] = count_dir_change[0];
  assign raw_ev[18] = count_ext_reset[0];
  assign raw_ev[19] = count_match[1];
  assign raw_ev[20] = count_dir_change[1];
  assign raw_ev[21] = count_ext_reset[1];
  assign raw_ev[22] = count_match[2];
  assign raw_ev[23] = count_dir_change[2];
  assign raw_ev[24] = count_ext_reset[2];
  assign raw_ev[25] = count_match[3];
  assign raw_ev[26] = count_match[4];
  assign raw_ev[27] = count_dir_change[4];
  assign raw_ev[28] = count_ext_reset[4];
  assign raw_ev[29] = count_match[5];
  assign raw_ev[30] = timed_tick[0];
  assign raw_ev[31] = timed_tick[1];
  assign raw_ev[32] = fast_on_delay_timer_a_done;
  assign raw_ev[33] = fast_on_delay_timer_b_done;

  generate
    for (g = 0; g < N; g = g + 1) begin : g_pend
      event_pending_bit u_pend (
        .clk(clk),
        .rst_b(rst_b),
        .set(raw_ev[g]),
        .take(take_vec[g]),
        .pend_q(pend[g])
      );
    end
  endgenerate

  // lowest index wins: group first, then in-group priority
  always @* begin
    sel_idx = 6'h00;
    sel_any = 1'b0;
    for (i = N - 1; i >= 0; i = i - 1) begin
      if (pend[i]) begin
        sel_idx = i[5:0];
        sel_any = 1'b1;
      end
    end
  end

  // index to event number, group and in-group rank
  always @* begin
    num_of = 6'h00;
    grp_of = `GRP_DISC;
    rank_of = 5'h00;
    case (sel_idx)
      6'd0: begin
        num_of = `EV_P0_RX_CHAR;
        grp_of = `GRP_COMM;
      end
      6'd1: begin
        num_of = `EV_P0_TX_DONE;
        grp_of = `GRP_COMM;
      end
      6'd2: begin
        num_of = `EV_P0_RX_MSG;
        grp_of = `GRP_COMM;
      end
      6'd3: begin
        num_of = `EV_P1_RX_MSG;
        grp_of = `GRP_COMM;
        rank_of = 5'h01;
      end
      6'd4: begin
        num_of = `EV_P1_RX_CHAR;
        grp_of = `GRP_COMM;
        rank_of = 5'h01;
      end
      6'd5: begin
        num_of = `EV_P1_TX_DONE;
        grp_of = `GRP_COMM;
        rank_of = 5'h01;
      end
      6'd6: num_of = `EV_PULSE0_DONE;
      6'd7: begin
        num_of = `EV_PULSE1_DONE;
        rank_of = 5'h01;
      end
      6'd8: begin
        num_of = `EV_RISE_0;
        rank_of = 5'h02;
      end
      6'd9: begin
        num_of = `EV_RISE_1;
        rank_of = 5'h03;
      end
      6'd10: begin
        num_of = `EV_RISE_2;
        rank_of = 5'h04;
      end
      6'd11: begin
        num_of = `EV_RISE_3;
        rank_of = 5'h05;
      end
      6'd12: begin
        num_of = `EV_FALL_0;
        rank_of = 5'h06;
      end
      6'd13: begin
        num_of = `EV_FALL_1;
        rank_of = 5'h07;
      end
      6'd14: begin
        num_of = `EV_FALL_2;
        rank_of = 5'h08;
      end
      6'd15: begin
        num_of = `EV_FALL_3;
        rank_of = 5'h09;
      end
      6'd16: begin
        num_of = `EV_FC0_EQ;
        rank_of = 5'h0A;
      end
      6'd17: begin
        num_of = `EV_FC0_DIR;
        rank_of = 5'h0B;
      end
      6'd18: begin
        num_of = `EV_FC0_RST;
        rank_of = 5'h0C;
      end
      6'd19: begin
        num_of = `EV_FC1_EQ;
        rank_of = 5'h0D;
      end
      6'd20: begin
        num_of = `EV_FC1_DIR;
        rank_of = 5'h0E;
      end
      6'd21: begin
        num_of = `EV_FC1_RST;
        rank_of = 5'h0F;
      end
      6'd22: begin
        num_of = `EV_FC2_EQ;
        rank_of = 5'h10;
      end
      6'd23: begin
        num_of = `EV_FC2_DIR;
        rank_of = 5'h11;
      end
      6'd24: begin
        num_of = `EV_FC2_RST;
        rank_of = 5'h12;
      end
      6'd25: begin
        num_of = `EV_FC3_EQ;
        rank_of = 5'h13;
      end
      6'd26: begin
        num_of = `EV_FC4_EQ;
        rank_of = 5'h14;
      end
      6'd27: begin
        num_of = `EV_FC4_DIR;
        rank_of = 5'h15;
      end
      6'd28: begin
        num_of = `EV_FC4_RST;
        rank_of = 5'h16;
      end
      6'd29: begin
        num_of = `EV_FC5_EQ;
        rank_of = 5'h17;
      end
      6'd30: begin
        num_of = `EV_TIMED_0;
        grp_of = `GRP_TIME;
      end
      6'd31: begin
        num_of = `EV_TIMED_1;
        grp_of = `GRP_TIME;
        rank_of = 5'h01;
      end
      6'd32: begin
        num_of = `EV_TMR_A;
        grp_of = `GRP_TIME;
        rank_of = 5'h02;
      end
      6'd33: begin
        num_of = `EV_TMR_B;
        grp_of = `GRP_TIME;
        rank_of = 5'h03;
      end
      default: begin
        num_of = 6'h00;
        grp_of = `GRP_DISC;
        rank_of = 5'h00;
      end
    endcase
  end

  // presented slot: freeze while valid so the core sees a stable event
  reg [5:0] held_idx_q;
  always @(posedge clk) begin
    if (!rst_b) begin
      event_valid_q <= 1'b0;
      event_num_q <= 6'h00;
      event_group_q <= 2'h0;
      event_rank_q <= 5'h00;
      held_idx_q <= 6'h00;
    end else if (!event_valid_q || event_take) begin
      // after a take, one idle cycle lets the flag clear before re-pick
      event_valid_q <= sel_any && !event_valid_q;
      if (sel_any && !event_valid_q) begin
        event_num_q <= num_of;
        event_group_q <= grp_of;
        event_rank_q <= rank_of;
        held_idx_q <= sel_idx;
      end
    end
  end

  // only the handed-over event is cleared, one per dispatch
  always @* begin
    take_vec = {N{1'b0}};
    for (j = 0; j < N; j = j + 1) begin
      if (event_valid_q && event_take && held_idx_q == j[5:0]) begin
        take_vec[j] = 1'b1;
      end
    end
  end
endmodule // plc_interrupt_event_prioritizer

// ==== event_prio_regs.vh ====
// Purpose: constants for the interrupt event prioritizer
// Assumes: 34 event sources, numbered 0..33
// Notes: event numbers are the numbers handed to the processor core
`ifndef EVENT_PRIO_REGS_VH
`define EVENT_PRIO_REGS_VH
`define EV_COUNT 34
`define EV_NUM_W 6
`define GRP_COMM 2'h0
`define GRP_DISC 2'h1
`define GRP_TIME 2'h2
`define EV_P0_RX_CHAR 6'h08
`define EV_P0_TX_DONE 6'h09
`define EV_P0_RX_MSG 6'h17
`define EV_P1_RX_MSG 6'h18
`define EV_P1_RX_CHAR 6'h19
`define EV_P1_TX_DONE 6'h1A
`define EV_PULSE0_DONE 6'h13
`define EV_PULSE1_DONE 6'h14
`define EV_RISE_0 6'h00
`define EV_RISE_1 6'h02
`define EV_RISE_2 6'h04
`define EV_RISE_3 6'h06
`define EV_FALL_0 6'h01
`define EV_FALL_1 6'h03
`define EV_FALL_2 6'h05
`define EV_FALL_3 6'h07
`define EV_FC0_EQ 6'h0C
`define EV_FC0_DIR 6'h1B
`define EV_FC0_RST 6'h1C
`define EV_FC1_EQ 6'h0D
`define EV_FC1_DIR 6'h0E
`define EV_FC1_RST 6'h0F
`define EV_FC2_EQ 6'h10
`define EV_FC2_DIR 6'h11
`define EV_FC2_RST 6'h12
`define EV_FC3_EQ 6'h20
`define EV_FC4_EQ 6'h1D
`define EV_FC4_DIR 6'h1E
`define EV_FC4_RST 6'h1F
`define EV_FC5_EQ 6'h21
`define EV_TIMED_0 6'h0A
`define EV_TIMED_1 6'h0B
`define EV_TMR_A 6'h15
`define EV_TMR_B 6'h16
`endif

// ==== input_sync.v ====
// Purpose: three-flop synchroniser with agreement filter for one pin
// Assumes: pin is asynchronous to clk
// Notes: first flop feeds only the second
`timescale 1ns/1ns
module input_sync (
  input wire clk,
  input wire rst_b,
  input wire pin,
  output reg level_q
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  always @(posedge clk) begin
    if (!rst_b) begin
      // chain keeps sampling in reset so a pin already high at release is no edge
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      level_q <= s3_q;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // change counts only once second and third stages agree
      if (s2_q == s3_q) begin
        level_q <= s3_q;
      end
    end
  end
endmodule // input_sync

// ==== event_pending_bit.v ====
// Purpose: one sticky pending flag per event source
// Assumes: set and take are one-cycle pulses on clk
// Notes: a set in the same cycle as a take wins
`timescale 1ns/1ns
module event_pending_bit (
  input wire clk,
  input wire rst_b,
  input wire set,
  input wire take,
  output reg pend_q
);
  always @(posedge clk) begin
    if (!rst_b) begin
      pend_q <= 1'b0;
    end else if (set) begin
      pend_q <= 1'b1;
    end else if (take) begin
      pend_q <= 1'b0;
    end
  end
endmodule // event_pending_bit

// ==== prio_assertions.sv ====
// Purpose: port-level checks of the event prioritizer
// Assumes: one clock domain, rst_b synchronous active low
// Notes: bound from the testbench top file
`timescale 1ns/1ns
module prio_assertions (
  input wire clk,
  input wire rst_b,
  input wire port0_rx_char,
  input wire event_take,
  input wire event_valid_q,
  input wire [5:0] event_num_q,
  input wire [1:0] event_group_q,
  input wire [4:0] event_rank_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire v = event_valid_q;
  wire [5:0] n = event_num_q;
  wire [1:0] g = event_group_q;
  wire [4:0] r = event_rank_q;
  sequence s_take;
    v && event_take;
  endsequence
  a_valid_holds: assert property (v && !event_take |=> v && $stable({n, g, r}))
    else $error("presented event changed before take");
  a_take_gap: assert property (s_take |=> !v)
    else $error("valid stayed after take");
  a_group_range: assert property (v |-> (g == 2'h0 && r <= 5'h01) ||
    (g == 2'h1 && r <= 5'h17) || (g == 2'h2 && r <= 5'h03)) else $error("bad group or rank");
  a_comm_nums: assert property (v && g == 2'h0 |->
    (r == 5'h00 && n inside {6'h08, 6'h09, 6'h17}) || (r == 5'h01 && n inside {6'h18, 6'h19, 6'h1A}))
    else $error("bad comm number");
  a_timed_nums: assert property (v && g == 2'h2 |-> n == (r < 5'h02 ? 6'h0A + r : 6'h13 + r))
    else $error("bad timed number");
  a_pto_nums: assert property (v && g == 2'h1 && r < 5'h02 |-> n == 6'h13 + r)
    else $error("bad pulse train number");
  a_edge_nums: assert property (v && g == 2'h1 && r inside {[5'h02:5'h09]} |->
    n == (r < 5'h06 ? {r - 5'h02, 1'b0} : {r - 5'h06, 1'b1})) else $error("bad edge number");
  a_fc_nums: assert property (v && g == 2'h1 |-> (n == 6'h20) == (r == 5'h13) &&
    (n == 6'h21) == (r == 5'h17) && (n == 6'h0C) == (r == 5'h0A)) else $error("bad counter number");
  a_rx_answer: assert property (port0_rx_char && !v |-> ##2 v)
    else $error("event not presented in time");
endmodule // prio_assertions

// ==== isr_core_model.sv ====
// Purpose: processor core that accepts presented events
// Assumes: take is sampled with valid on the same edge
// Notes: slow mode lets several events queue up before each take
`timescale 1ns/1ns
module isr_core_model (
  input wire clk,
  input wire rst_b,
  input wire event_valid_q,
  input wire slow,
  output logic event_take
);
  logic [2:0] wait_q;
  always @(posedge clk) begin
    if (!rst_b) begin
      event_take <= 1'b0;
      wait_q <= 3'h0;
    end else if (event_take) begin
      event_take <= 1'b0;
    end else if (event_valid_q) begin
      // one take per presented event
      if (wait_q == (slow ? 3'h4 : 3'h0)) begin
        event_take <= 1'b1;
        wait_q <= 3'h0;
      end else begin
        wait_q <= wait_q + 3'h1;
      end
    end
  end
endmodule // isr_core_model

// ==== test_plc_interrupt_event_prioritizer.sv ====
// Purpose: self-checking bench for the event prioritizer
// Assumes: the core model takes each presented event
// Notes: counter bit 3 has no direction or reset event; it is driven to show it is ignored
`timescale 1ns/1ns
module test_plc_interrupt_event_prioritizer;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic slow = 1'b0;
  logic [25:0] ev = 26'h0;
  logic [3:0] din = 4'h0;
  logic [1:0] c3x = 2'h0;
  wire take, valid;
  wire [5:0] num;
  wire [1:0] grp;
  wire [4:0] rank;
  int fails = 0;
  int checked = 0;
  logic [5:0] en [26] = '{8, 9, 23, 24, 25, 26, 19, 20, 12, 13, 16, 32, 29, 33,
    27, 14, 17, 30, 28, 15, 18, 31, 10, 11, 21, 22};
  logic [4:0] er [26] = '{0, 0, 0, 1, 1, 1, 0, 1, 10, 13, 16, 19, 20, 23,
    11, 14, 17, 21, 12, 15, 18, 22, 0, 1, 2, 3};
  logic [13:0] v;
  logic [13:0] q[$];
  always #2 clk = ~clk;
  plc_interrupt_event_prioritizer i_dut (.clk(clk), .rst_b(rst_b),
    .port0_rx_char(ev[0]), .port0_tx_done(ev[1]), .port0_rx_msg(ev[2]),
    .port1_rx_msg(ev[3]), .port1_rx_char(ev[4]), .port1_tx_done(ev[5]),
    .pulse_train_out_0_done(ev[6]), .pulse_train_out_1_done(ev[7]),
    .discrete_input(din), .count_match(ev[13:8]),
    .count_dir_change({ev[17], c3x[0], ev[16:14]}),
    .count_ext_reset({ev[21], c3x[1], ev[20:18]}),
    .timed_tick(ev[23:22]), .fast_on_delay_timer_a_done(ev[24]),
    .fast_on_delay_timer_b_done(ev[25]), .event_take(take), .event_valid_q(valid),
    .event_num_q(num), .event_group_q(grp), .event_rank_q(rank));
  isr_core_model u_core (.clk(clk), .rst_b(rst_b), .event_valid_q(valid), .slow(slow),
    .event_take(take));
  function automatic logic [1:0] gof(int i);
    return i < 6 ? 2'h0 : i < 22 ? 2'h1 : 2'h2;
  endfunction
  task report_and_stop;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task tick;
    @(posedge clk);
    #1;
  endtask
  task cmp(input logic [13:0] got, input logic [13:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask
  task waitv(input logic lvl);
    for (int n = 0; valid !== lvl; n++) begin
      if (n == 60) begin
        fails++;
        $display("CHECK FAILED %0t timeout waiting for valid", $time);
        report_and_stop;
      end
      tick;
    end
  endtask
  task grab;
    waitv(1'b1);
    v = {valid, num, grp, rank};
    waitv(1'b0);
  endtask
  initial begin
    repeat (12) tick;
    cmp({valid, num, grp, rank}, 14'h0);
    rst_b = 1'b1;
    tick;
    for (int i = 0; i < 26; i++) begin
      ev = 26'h1 << i;
      tick;
      ev = 26'h0;
      grab;
      cmp(v, {1'b1, en[i], gof(i), er[i]});
    end
    $display("single source table done");
    for (int k = 0; k < 4; k++) begin
      din[k] = 1'b1;
      grab;
      cmp(v, {1'b1, 6'(2 * k), 2'h1, 5'(2 + k)});
      din[k] = 1'b0;
      grab;
      cmp(v, {1'b1, 6'(2 * k + 1), 2'h1, 5'(6 + k)});
    end
    $display("pin edge test done");
    // all 26 non-pin sources at once, pin edges not driven; equal ranks may come in any order, so numbers are masked
    for (int g = 0; g < 3; g++)
      for (int r = 0; r < 24; r++)
        for (int i = 0; i < 26; i++)
          if (gof(i) == g && er[i] == r)
            q.push_back({1'b1, 6'h0, 2'(g), 5'(r)});
    slow = 1'b1;
    ev = 26'h3FFFFFF;
    tick;
    ev = 26'h0;
    foreach (q[j]) begin
      grab;
      cmp({v[13], 6'h0, v[6:0]}, q[j]);
    end
    $display("priority order test done");
    slow = 1'b0;
    ev = 26'h1;
    repeat (3) tick;
    ev = 26'h0;
    grab;
    cmp(v, {1'b1, 6'h08, 2'h0, 5'h00});
    repeat (10) tick;
    cmp({13'h0, valid}, 14'h0);
    $display("merge test done");
    // pulse still high in the take cycle: the flag must survive and be presented again
    ev = 26'h1;
    grab;
    cmp(v, {1'b1, 6'h08, 2'h0, 5'h00});
    ev = 26'h0;
    grab;
    cmp(v, {1'b1, 6'h08, 2'h0, 5'h00});
    $display("set in take cycle test done");
    c3x = 2'h3;
    tick;
    c3x = 2'h0;
    repeat (10) tick;
    cmp({13'h0, valid}, 14'h0);
    $display("counter 3 extra input test done");
    rst_b = 1'b0;
    din = 4'hF;
    repeat (12) tick;
    cmp({valid, num, grp, rank}, 14'h0);
    rst_b = 1'b1;
    repeat (20) tick;
    cmp({13'h0, valid}, 14'h0);
    din = 4'h0;
    for (int k = 0; k < 4; k++) begin
      grab;
      cmp(v, {1'b1, 6'(2 * k + 1), 2'h1, 5'(6 + k)});
    end
    $display("reset with pins high test done");
    report_and_stop;
  end
endmodule // test_plc_interrupt_event_prioritizer
bind plc_interrupt_event_prioritizer prio_assertions u_chk (.*);
